//--- adx_consts.svh
// Offsets, field positions, reset values and limits of the data exchange block
`ifndef ADX_CONSTS_SVH
`define ADX_CONSTS_SVH

// Byte offsets from the second module base
`define ADX_CTRL_OFS 8'h30
`define ADX_IN1L_OFS 8'h34
`define ADX_IN3L_OFS 8'h44
`define ADX_IN1R_OFS 8'h54
`define ADX_IN3R_OFS 8'h64
`define ADX_ST_OFS 8'h74
`define ADX_OUT1L_OFS 8'h34
`define ADX_OUT1R_OFS 8'h44
`define ADX_OUT2L_OFS 8'h54
`define ADX_OUT2R_OFS 8'h64
`define ADX_IRQ_STAT_OFS 8'h84
`define ADX_IRQ_CLR_OFS 8'h88
`define ADX_IRQ_EN_OFS 8'h8c
`define ADX_LEVEL_OFS 8'h90
// Span of a multiple-decoded window, last word minus first
`define ADX_WIN_SPAN 8'h0c

// Control register reset value and writable bits
`define ADX_CTRL_RST 32'h0000_0000
`define ADX_CTRL_MASK 32'h00ff_ffff

// Control field positions, ports indexed 0..2 for in1, in2, in3
`define ADX_SEL1_HI 12
`define ADX_SEL1_LO 0
`define ADX_SEL2_HI 13
`define ADX_SEL2_LO 3
`define ADX_SEL3_LO 16
`define ADX_ZERO1 10
`define ADX_ZERO2 11
`define ADX_ZERO3 23
`define ADX_RST1 8
`define ADX_RST2 9
`define ADX_RST3 22
`define ADX_THR1_LO 6
`define ADX_THR2_LO 14
`define ADX_THR3_LO 20

// FIFO geometry and full thresholds
`define ADX_DEPTH 3'd6
`define ADX_LAST_SLOT 3'd5
`define ADX_FLUSH_LEVEL 3'd1
`define ADX_THR_00 3'd1
`define ADX_THR_01 3'd2
`define ADX_THR_10 3'd3
`define ADX_THR_11 3'd6

// Interrupt events: full rise per port, then overflow per port
`define ADX_NUM_EVT 6
`define ADX_EVT_OVF_LO 3

`endif

//--- adx_pkg.sv
// Types shared by the data exchange block
package adx_pkg;

    typedef logic [19:0] adx_sample_t;
    typedef logic [2:0] adx_count_t;

    typedef enum logic [3:0] {
        ADX_SRC_OFF = 4'h0,
        ADX_SRC_OUT_ONE = 4'h1,
        ADX_SRC_OUT_TWO = 4'h2,
        ADX_SRC_UNUSED = 4'h3,
        ADX_SRC_SERIAL_RX_ONE = 4'h4,
        ADX_SRC_SERIAL_RX_THREE = 4'h5,
        ADX_SRC_SERIAL_RX_FOUR = 4'h6,
        ADX_SRC_DIGITAL_RX_ONE = 4'h7,
        ADX_SRC_DIGITAL_RX_TWO = 4'h8
    } adx_src_e;

endpackage : adx_pkg

//--- adx_in_fifo.sv
// One channel of an input FIFO: six samples, flush to one remaining
`timescale 1ns/100ps
`include "adx_consts.svh"
module adx_in_fifo
    import adx_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic push,
    input wire adx_sample_t push_data,
    input wire logic pop,
    input wire logic flush,
    output adx_sample_t head,
    output adx_count_t level,
    output logic overflow
);

    adx_sample_t mem [6];
    adx_count_t wr_ptr;
    adx_count_t rd_ptr;
    logic do_push;
    logic do_pop;

    function automatic adx_count_t adx_inc(input adx_count_t p);
        adx_inc = (p == `ADX_LAST_SLOT) ? 3'h0 : 3'(p + 3'h1);
    endfunction : adx_inc

    // A push into a full FIFO is dropped unless a pop frees the slot
    assign do_pop = pop && (level != 3'h0) && !flush;
    assign do_push = push && !flush && ((level != `ADX_DEPTH) || do_pop);
    assign overflow = push && !flush && !do_push;
    assign head = mem[rd_ptr];

    // Pointers and fill; flush keeps the oldest sample as the one left
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            level <= 3'h0;
        end else if (flush) begin
            wr_ptr <= adx_inc(rd_ptr);
            level <= `ADX_FLUSH_LEVEL;
        end else begin
            if (do_push) begin
                wr_ptr <= adx_inc(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= adx_inc(rd_ptr);
            end
            level <= 3'(level + {2'h0, do_push} - {2'h0, do_pop});
        end
    end

    // Sample storage, cleared so a flushed FIFO never reads unknowns
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 6; i++) begin
                mem[i] <= 20'h0;
            end
        end else if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

endmodule : adx_in_fifo

//--- adx_irq.sv
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/100ps
`include "adx_consts.svh"
module adx_irq
    import adx_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [`ADX_NUM_EVT-1:0] event_in,
    input wire logic clr_wr,
    input wire logic en_wr,
    input wire logic [`ADX_NUM_EVT-1:0] wr_bits,
    output logic [`ADX_NUM_EVT-1:0] status,
    output logic [`ADX_NUM_EVT-1:0] enable,
    output logic irq
);

    logic [`ADX_NUM_EVT-1:0] clr_bits;
    logic [`ADX_NUM_EVT-1:0] next_status;

    // A new event beats a clear in the same cycle
    assign clr_bits = clr_wr ? wr_bits : '0;
    assign next_status = (status & ~clr_bits) | event_in;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            enable <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            if (en_wr) begin
                enable <= wr_bits;
            end
            irq <= |(status & enable);
        end
    end

endmodule : adx_irq

//--- adx_exchange.sv
// Processor data exchange: output data ports and three input FIFOs
//
// Functional notes
// - Output port one: left and right registers, each at four word addresses.
// - Output port two behaves like port one and feeds the audio FIFOs.
// - Output port three: one stereo register, 16-bit halves, four addresses.
// - Input port one source chosen by control bits 12 and 2:0.
// - Input port two: stereo 16-bit halves, source by bits 13 and 5:3.
// - Input port three like port one, source by control bits 19:16.
// - Every input FIFO holds six samples and has a programmable full level.
// - Zero bit set makes reads of that input port return zero.
// - Reset bit set holds that FIFO at one sample remaining.
// - Full select codes 00..11 mean at least 1, 2, 3 or 6 samples.
// - Control register lives at 0x30 and resets to zero, sources off.
// - Left and right data registers carry twenty sample bits in the given 32-bit format.
`timescale 1ns/100ps
`include "adx_consts.svh"
module adx_exchange
    import adx_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [4:0] rx_left_valid,
    input wire logic [4:0][19:0] rx_left_data,
    input wire logic [4:0] rx_right_valid,
    input wire logic [4:0][19:0] rx_right_data,
    output logic out1_left_valid,
    output adx_sample_t out1_left_data,
    output logic out1_right_valid,
    output adx_sample_t out1_right_data,
    output logic out2_left_valid,
    output adx_sample_t out2_left_data,
    output logic out2_right_valid,
    output adx_sample_t out2_right_data,
    output logic out3_valid,
    output adx_sample_t out3_left_data,
    output adx_sample_t out3_right_data,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // True for the four word addresses of one multiple-decoded window
    function automatic logic adx_win(input logic [7:0] a,
                                     input logic [7:0] base);
        adx_win = (a >= base) && (a <= 8'(base + `ADX_WIN_SPAN))
                  && (a[1:0] == 2'h0);
    endfunction : adx_win

    // Twenty-bit sample in the left/right register layout
    function automatic logic [31:0] adx_fmt(input adx_sample_t s);
        adx_fmt = {~s[19], s[19], s, 10'h0};
    endfunction : adx_fmt

    // Full threshold for a two-bit select code
    function automatic adx_count_t adx_thr(input logic [1:0] code);
        case (code)
            2'h0: adx_thr = `ADX_THR_00;
            2'h1: adx_thr = `ADX_THR_01;
            2'h2: adx_thr = `ADX_THR_10;
            default: adx_thr = `ADX_THR_11;
        endcase
    endfunction : adx_thr

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [31:0] data_in_source_control;
    logic [31:0] next_rdata;
    logic ctrl_wr;
    logic [3:0] sel [3];
    logic [2:0] zero;
    logic [2:0] flush;
    logic [2:0] full;
    logic [2:0] full_q;
    logic [2:0] push_l;
    logic [2:0] push_r;
    logic [2:0] pop_l;
    logic [2:0] pop_r;
    logic [2:0] ovf_l;
    logic [2:0] ovf_r;
    adx_sample_t pdata_l [3];
    adx_sample_t pdata_r [3];
    adx_sample_t head_l [3];
    adx_sample_t head_r [3];
    adx_count_t lvl_l [3];
    adx_count_t lvl_r [3];
    logic [1:0] thr_code [3];
    logic [15:0] src_lv;
    logic [15:0] src_rv;
    logic [15:0][19:0] src_ld;
    logic [15:0][19:0] src_rd;
    logic [`ADX_NUM_EVT-1:0] evt;
    logic [`ADX_NUM_EVT-1:0] irq_stat;
    logic [`ADX_NUM_EVT-1:0] irq_en;
    logic [31:0] level_word;
    logic w_out1l, w_out1r, w_out2l, w_out2r, w_out3;
    logic r_in1l, r_in1r, r_in3l, r_in3r, r_st;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Input and output ports share windows; the strobe picks the direction
    assign ctrl_wr = wr && (addr == `ADX_CTRL_OFS);
    assign w_out1l = wr && adx_win(addr, `ADX_OUT1L_OFS);
    assign w_out1r = wr && adx_win(addr, `ADX_OUT1R_OFS);
    assign w_out2l = wr && adx_win(addr, `ADX_OUT2L_OFS);
    assign w_out2r = wr && adx_win(addr, `ADX_OUT2R_OFS);
    assign w_out3 = wr && adx_win(addr, `ADX_ST_OFS);
    assign r_in1l = rd && adx_win(addr, `ADX_IN1L_OFS);
    assign r_in1r = rd && adx_win(addr, `ADX_IN1R_OFS);
    assign r_in3l = rd && adx_win(addr, `ADX_IN3L_OFS);
    assign r_in3r = rd && adx_win(addr, `ADX_IN3R_OFS);
    assign r_st = rd && adx_win(addr, `ADX_ST_OFS);

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            data_in_source_control <= `ADX_CTRL_RST;
        end else if (ctrl_wr) begin
            data_in_source_control <= wdata & `ADX_CTRL_MASK;
        end
    end

    // Control fields per input port
    assign sel[0] = {data_in_source_control[`ADX_SEL1_HI],
                     data_in_source_control[`ADX_SEL1_LO +: 3]};
    assign sel[1] = {data_in_source_control[`ADX_SEL2_HI],
                     data_in_source_control[`ADX_SEL2_LO +: 3]};
    assign sel[2] = data_in_source_control[`ADX_SEL3_LO +: 4];
    assign zero = {data_in_source_control[`ADX_ZERO3],
                   data_in_source_control[`ADX_ZERO2],
                   data_in_source_control[`ADX_ZERO1]};
    assign flush = {data_in_source_control[`ADX_RST3],
                    data_in_source_control[`ADX_RST2],
                    data_in_source_control[`ADX_RST1]};
    assign thr_code[0] = data_in_source_control[`ADX_THR1_LO +: 2];
    assign thr_code[1] = data_in_source_control[`ADX_THR2_LO +: 2];
    assign thr_code[2] = data_in_source_control[`ADX_THR3_LO +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Output data ports

    // Ports one and two keep only the twenty significant bits; low bits are disregarded
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out1_left_data <= 20'h0;
            out1_right_data <= 20'h0;
            out2_left_data <= 20'h0;
            out2_right_data <= 20'h0;
            out3_left_data <= 20'h0;
            out3_right_data <= 20'h0;
        end else begin
            if (w_out1l) out1_left_data <= wdata[29:10];
            if (w_out1r) out1_right_data <= wdata[29:10];
            if (w_out2l) out2_left_data <= wdata[29:10];
            if (w_out2r) out2_right_data <= wdata[29:10];
            if (w_out3) begin
                out3_left_data <= {wdata[31:16], 4'h0};
                out3_right_data <= {wdata[15:0], 4'h0};
            end
        end
    end

    // One-cycle strobes announce each written sample to the audio FIFOs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out1_left_valid <= 1'b0;
            out1_right_valid <= 1'b0;
            out2_left_valid <= 1'b0;
            out2_right_valid <= 1'b0;
            out3_valid <= 1'b0;
        end else begin
            out1_left_valid <= w_out1l;
            out1_right_valid <= w_out1r;
            out2_left_valid <= w_out2l;
            out2_right_valid <= w_out2r;
            out3_valid <= w_out3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source multiplexers

    // Codes 0, 3 and above 8 select nothing, so no sample is pushed
    assign src_lv = {7'h0, rx_left_valid, 1'b0, out2_left_valid,
                     out1_left_valid, 1'b0};
    assign src_rv = {7'h0, rx_right_valid, 1'b0, out2_right_valid,
                     out1_right_valid, 1'b0};
    assign src_ld = {{7{20'h0}}, rx_left_data, 20'h0, out2_left_data,
                     out1_left_data, 20'h0};
    assign src_rd = {{7{20'h0}}, rx_right_data, 20'h0, out2_right_data,
                     out1_right_data, 20'h0};

    ////////////////////////////////////////////////////////////////////////
    // Input FIFOs, a left and a right half for each port

    // Port two pops both halves on one read, keeping them paired
    assign pop_l = {r_in3l, r_st, r_in1l};
    assign pop_r = {r_in3r, r_st, r_in1r};

    for (genvar p = 0; p < 3; p++) begin : g_port
        assign push_l[p] = src_lv[sel[p]];
        assign push_r[p] = src_rv[sel[p]];
        assign pdata_l[p] = src_ld[sel[p]];
        assign pdata_r[p] = src_rd[sel[p]];
        // Full follows the left half only; the right half level lvl_r is ignored
        assign full[p] = lvl_l[p] >= adx_thr(thr_code[p]);

        adx_in_fifo u_left (
            .mclk(mclk),
            .rstn(rstn),
            .push(push_l[p]),
            .push_data(pdata_l[p]),
            .pop(pop_l[p]),
            .flush(flush[p]),
            .head(head_l[p]),
            .level(lvl_l[p]),
            .overflow(ovf_l[p])
        );

        adx_in_fifo u_right (
            .mclk(mclk),
            .rstn(rstn),
            .push(push_r[p]),
            .push_data(pdata_r[p]),
            .pop(pop_r[p]),
            .flush(flush[p]),
            .head(head_r[p]),
            .level(lvl_r[p]),
            .overflow(ovf_r[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Edge of full, so a FIFO sitting full raises its bit only once
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            full_q <= 3'h0;
        end else begin
            full_q <= full;
        end
    end

    assign evt = {ovf_l | ovf_r, full & ~full_q};

    adx_irq u_irq (
        .mclk(mclk),
        .rstn(rstn),
        .event_in(evt),
        .clr_wr(wr && (addr == `ADX_IRQ_CLR_OFS)),
        .en_wr(wr && (addr == `ADX_IRQ_EN_OFS)),
        .wr_bits(wdata[`ADX_NUM_EVT-1:0]),
        .status(irq_stat),
        .enable(irq_en),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data

    assign level_word = {14'h0, lvl_r[2], lvl_l[2], lvl_r[1], lvl_l[1],
                         lvl_r[0], lvl_l[0]};

    // Zeroed ports still pop, so the stream keeps its pace while muted
    assign next_rdata =
        !rd ? 32'h0 :
        (addr == `ADX_CTRL_OFS) ? data_in_source_control :
        r_in1l ? (zero[0] ? 32'h0 : adx_fmt(head_l[0])) :
        r_in1r ? (zero[0] ? 32'h0 : adx_fmt(head_r[0])) :
        r_in3l ? (zero[2] ? 32'h0 : adx_fmt(head_l[2])) :
        r_in3r ? (zero[2] ? 32'h0 : adx_fmt(head_r[2])) :
        r_st ? (zero[1] ? 32'h0 :
                {head_l[1][19:4], head_r[1][19:4]}) :
        (addr == `ADX_IRQ_STAT_OFS) ? {26'h0, irq_stat} :
        (addr == `ADX_IRQ_EN_OFS) ? {26'h0, irq_en} :
        (addr == `ADX_LEVEL_OFS) ? level_word :
        32'h0;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_ctrl_write;
        wr && (addr == `ADX_CTRL_OFS);
    endsequence

    sequence s_out_one_push;
        (sel[0] == ADX_SRC_OUT_ONE) && out1_left_valid && !pop_l[0]
        && !flush[0] && (lvl_l[0] < `ADX_DEPTH);
    endsequence

    AST_CTRL_WRITE: assert property (s_ctrl_write |=>
        data_in_source_control == ($past(wdata) & `ADX_CTRL_MASK))
        else $error("control register did not take the write");

    AST_OUT1_WRITE: assert property (w_out1l |=> out1_left_valid
        && (out1_left_data == $past(wdata[29:10])))
        else $error("output port one left sample wrong");

    AST_OUT2_WRITE: assert property (w_out2r |=> out2_right_valid
        && (out2_right_data == $past(wdata[29:10]))
        ##1 (out2_right_valid == $past(w_out2r)))
        else $error("output port two right strobe wrong");

    AST_OUT3_WRITE: assert property (w_out3 |=> out3_valid
        && (out3_left_data == {$past(wdata[31:16]), 4'h0})
        && (out3_right_data == {$past(wdata[15:0]), 4'h0}))
        else $error("output port three stereo sample wrong");

    AST_SRC_PUSH: assert property (s_out_one_push |=>
        lvl_l[0] == 3'($past(lvl_l[0]) + 3'h1))
        else $error("port one did not fill from output port one");

    AST_STEREO_READ: assert property (r_st && !zero[1] |=>
        rdata == {$past(head_l[1][19:4]), $past(head_r[1][19:4])})
        else $error("port two stereo read wrong");

    AST_OFF_STABLE: assert property ((sel[2] == ADX_SRC_OFF)
        && !pop_l[2] && !flush[2] |=> $stable(lvl_l[2]))
        else $error("port three filled while its source is off");

    AST_ZERO_READ: assert property (r_in1l && zero[0] |=>
        rdata == 32'h0)
        else $error("zeroed port one returned data");

    AST_FLUSH_LEVEL: assert property (flush[0] [*2] |->
        (lvl_l[0] == `ADX_FLUSH_LEVEL) && (lvl_r[0] == `ADX_FLUSH_LEVEL))
        else $error("flushed FIFO not at one sample");

    AST_FULL_IRQ: assert property ($rose(full[1]) |=> irq_stat[1])
        else $error("full event lost");

    AST_LEFT_FMT: assert property (r_in1l && !zero[0] |=>
        rdata == adx_fmt($past(head_l[0])))
        else $error("left sample format wrong");

    AST_POP_ONE: assert property (r_in3r && !push_r[2] && !flush[2]
        && (lvl_r[2] != 3'h0) |=> lvl_r[2] == 3'($past(lvl_r[2]) - 3'h1))
        else $error("read did not pop exactly one sample");

    AST_DEPTH_CAP: assert property (lvl_l[1] <= `ADX_DEPTH)
        else $error("FIFO level above six");

endmodule : adx_exchange

//--- adx_rx_model.sv
// Model of the five audio receivers feeding the input FIFOs
`timescale 1ns/100ps
module adx_rx_model (
    input wire logic mclk,
    output logic [4:0] rx_left_valid,
    output logic [4:0][19:0] rx_left_data,
    output logic [4:0] rx_right_valid,
    output logic [4:0][19:0] rx_right_data
);
    // Idle receivers: strobes low, data not meaningful
    initial begin
        rx_left_valid = 5'h00;
        rx_right_valid = 5'h00;
        rx_left_data = '0;
        rx_right_data = '1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One stereo sample, strobe one cycle; data inverted afterwards so a
    // design that samples outside the strobe reads garbage, not the sample
    task automatic send(input int idx, input logic [19:0] l,
                        input logic [19:0] r);
        @(posedge mclk);
        rx_left_valid[idx] <= 1'b1;
        rx_right_valid[idx] <= 1'b1;
        rx_left_data[idx] <= l;
        rx_right_data[idx] <= r;
        @(posedge mclk);
        rx_left_valid[idx] <= 1'b0;
        rx_right_valid[idx] <= 1'b0;
        rx_left_data[idx] <= ~l;
        rx_right_data[idx] <= ~r;
    endtask : send
endmodule : adx_rx_model

//--- adx_exchange_test.sv
// Self-checking bench for the processor data exchange block
`timescale 1ns/100ps
module adx_exchange_test;
    import adx_pkg::*;
    logic mclk;
    logic rstn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [4:0] rx_left_valid;
    logic [4:0][19:0] rx_left_data;
    logic [4:0] rx_right_valid;
    logic [4:0][19:0] rx_right_data;
    logic [3:0] ov;
    adx_sample_t od [4];
    logic out3_valid;
    adx_sample_t out3_left_data;
    adx_sample_t out3_right_data;
    logic irq;
    int error_cnt = 0;
    int samples_checked = 0;
    int thr [4] = '{1, 2, 3, 6};

    adx_rx_model rx (.mclk(mclk), .rx_left_valid(rx_left_valid),
        .rx_left_data(rx_left_data), .rx_right_valid(rx_right_valid),
        .rx_right_data(rx_right_data));

    adx_exchange dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_left_valid(rx_left_valid),
        .rx_left_data(rx_left_data), .rx_right_valid(rx_right_valid),
        .rx_right_data(rx_right_data), .out1_left_valid(ov[0]),
        .out1_left_data(od[0]), .out1_right_valid(ov[1]),
        .out1_right_data(od[1]), .out2_left_valid(ov[2]),
        .out2_left_data(od[2]), .out2_right_valid(ov[3]),
        .out2_right_data(od[3]), .out3_valid(out3_valid),
        .out3_left_data(out3_left_data),
        .out3_right_data(out3_right_data), .irq(irq));

    // 10 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus cycles and sample formatting
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    // irq lags status by a cycle, so allow two edges
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge mclk);
        #1 chk(irq, exp);
    endtask : irq_chk

    function automatic logic [31:0] fl(input logic [19:0] s);
        return {~s[19], s[19], s, 10'h000};
    endfunction : fl

    task automatic print_verdict;
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [19:0] l;
        logic [19:0] r;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        rstn = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(8'h30, 32'h0000_0000);
        bus_wr(8'h30, 32'hff3f_f0ff);
        rd_chk(8'h30, 32'h003f_f0ff);
        rd_chk(8'hfc, 32'h0000_0000);
        // Every output window, first and last address
        for (int i = 0; i < 8; i++) begin
            v = 32'h9abc_de00 ^ (32'(i) << 10);
            bus_wr(8'h34 + 8'(16 * (i / 2) + 12 * (i % 2)), v);
            #1 chk(ov, 32'(4'h1 << (i / 2)));
            chk(od[i / 2], v[29:10]);
        end
        for (int j = 0; j < 2; j++) begin
            v = 32'h8765_4321 + j;
            bus_wr(j ? 8'h80 : 8'h74, v);
            #1 chk(out3_valid, 1);
            chk(out3_left_data, {v[31:16], 4'h0});
            chk(out3_right_data, {v[15:0], 4'h0});
        end
        // Every source code on input port one; off and unused stay empty
        for (int c = 0; c < 9; c++) begin
            l = 20'h8_1200 + 20'(c);
            r = 20'h3_4500 + 20'(c);
            v = 32'(c);
            bus_wr(8'h30, {19'h0, v[3], 9'h0, v[2:0]});
            if (c == 1 || c == 2) begin
                bus_wr(c == 1 ? 8'h34 : 8'h54, fl(l));
                bus_wr(c == 1 ? 8'h44 : 8'h64, fl(r));
            end else
                rx.send(c > 3 ? c - 4 : 0, l, r);
            repeat (2) @(posedge mclk);
            rd_chk(8'h90, (c == 0 || c == 3) ? 32'h0 : 32'h9);
            if (c != 0 && c != 3) begin
                rd_chk(8'h3c, fl(l));
                rd_chk(8'h60, fl(r));
            end
        end
        // Port two drained on its full interrupt, then forced to zero
        bus_wr(8'h30, 32'h0000_2000);
        bus_wr(8'h8c, 32'h0000_0002);
        rx.send(4, 20'habcde, 20'h12345);
        irq_chk(1'b1);
        rd_chk(8'h80, 32'habcd_1234);
        bus_wr(8'h30, 32'h0000_2800);
        rx.send(4, 20'h13579, 20'h2468a);
        rd_chk(8'h74, 32'h0000_0000);
        // Port three fed from output port one
        bus_wr(8'h30, 32'h0001_0000);
        bus_wr(8'h38, fl(20'h4_5678));
        bus_wr(8'h4c, fl(20'h9_abcd));
        rd_chk(8'h48, fl(20'h4_5678));
        rd_chk(8'h6c, fl(20'h9_abcd));
        bus_wr(8'h30, 32'h0081_0000);
        bus_wr(8'h34, fl(20'h1_1111));
        repeat (2) @(posedge mclk);
        rd_chk(8'h44, 32'h0000_0000);
        // Full threshold codes on port one, polled after each sample up to the threshold, code 11 up to all six
        bus_wr(8'h8c, 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            bus_wr(8'h30, 32'h104 | (c << 6));
            // Leftover sample is stale, so drain it with the port muted
            bus_wr(8'h30, 32'h404 | (c << 6));
            rd_chk(8'h90, 32'h9);
            rd_chk(8'h34, 32'h0);
            rd_chk(8'h54, 32'h0);
            bus_wr(8'h30, 32'h004 | (c << 6));
            bus_wr(8'h88, 32'h0000_003f);
            for (int n = 1; n <= thr[c]; n++) begin
                rx.send(0, 20'(n), 20'(n));
                irq_chk(n == thr[c]);
            end
        end
        // Seventh sample overflows; mask, unmask, clear
        rx.send(0, 20'h7, 20'h7);
        rd_chk(8'h84, 32'h0000_0009);
        bus_wr(8'h8c, 32'h0000_0000);
        irq_chk(1'b0);
        bus_wr(8'h8c, 32'h0000_003f);
        irq_chk(1'b1);
        bus_wr(8'h88, 32'h0000_003f);
        rd_chk(8'h84, 32'h0000_0000);
        irq_chk(1'b0);
        // Reset bit keeps only the oldest sample
        bus_wr(8'h30, 32'h0000_01c4);
        rd_chk(8'h90, 32'h0000_0009);
        rd_chk(8'h34, fl(20'h1));
        print_verdict();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #2_000_000;
        error_cnt++;
        print_verdict();
    end
endmodule : adx_exchange_test
